// ===== hw/dfz_map.svh
// Offsets, field positions, reset values and counts of the format/rate mode word
`ifndef DFZ_MAP_SVH
`define DFZ_MAP_SVH
// --------------------------------------------------------------------------
// Mode word layout
// --------------------------------------------------------------------------
`define DFZ_WORD_W 16
`define DFZ_SEL_HI_BIT 10
`define DFZ_SEL_LO_BIT 9
`define DFZ_SEL_THIS 2'h3
`define DFZ_FRAMING_BIT 0
`define DFZ_WS_POL_BIT 1
`define DFZ_SHARED_ATT_BIT 2
`define DFZ_SYSCLK_BIT 3
`define DFZ_MULT_LO_BIT 4
`define DFZ_MULT_HI_BIT 5
`define DFZ_GROUP_LO_BIT 6
`define DFZ_GROUP_HI_BIT 7
`define DFZ_ZERO_EN_BIT 8
`define DFZ_MODE_W 9
`define DFZ_MODE_RESET 9'h000
// --------------------------------------------------------------------------
// Rates, ratios and counts
// --------------------------------------------------------------------------
`define DFZ_INIT_CYCLES 1024
`define DFZ_ZERO_LIMIT 65536
`define DFZ_RATIO_384 9'h180
`define DFZ_RATIO_256 9'h100
`define DFZ_OSR_384 7'h30
`define DFZ_OSR_256 7'h40
`define DFZ_INTERP 4'h8
`define DFZ_LATENCY_EIGHTHS 7'h59
`define DFZ_HZ_441 17'h0_AC44
`define DFZ_HZ_48 17'h0_BB80
`define DFZ_HZ_32 17'h0_7D00
`define DFZ_SAMPLE_W 24
`define DFZ_MIDSCALE 24'h00_0000
`endif

// ===== hw/dfz_pkg.sv
// Types shared by the format/rate mode control block
package dfz_pkg;
   typedef enum logic [1:0] {
      DFZ_MULT_NORMAL = 2'h0,
      DFZ_MULT_DOUBLE = 2'h1,
      DFZ_MULT_HALF = 2'h2,
      DFZ_MULT_RSVD = 2'h3
   } dfz_multiple_type;
   typedef enum logic [1:0] {
      DFZ_GRP_441 = 2'h0,
      DFZ_GRP_48 = 2'h1,
      DFZ_GRP_32 = 2'h2,
      DFZ_GRP_RSVD = 2'h3
   } dfz_group_type;
   typedef enum logic [2:0] {
      DFZ_ST_HOLD = 3'b001,
      DFZ_ST_INIT = 3'b010,
      DFZ_ST_RUN = 3'b100
   } dfz_state_type;
endpackage

// ===== hw/dfz_if.sv
// Carrier between the top, the program port receiver and the zero-run detector
`timescale 1ns/100ps
`default_nettype none
interface dfz_if;
   logic prog_clk;
   logic prog_data;
   logic prog_latch;
   logic rx_enable;
   logic word_valid;
   logic [15:0] word;
   logic det_enable;
   logic bclk_rise;
   logic data_bit;
   logic zero_flag;
   modport top (output prog_clk, prog_data, prog_latch, rx_enable, det_enable, bclk_rise,
      data_bit, input word_valid, word, zero_flag);
   modport rx (input prog_clk, prog_data, prog_latch, rx_enable, output word_valid, word);
   modport det (input det_enable, bclk_rise, data_bit, output zero_flag);
endinterface
`default_nettype wire

// ===== hw/dfz_prog_rx.sv
// Three-wire program port receiver: shifts 16 bits, presents them on latch
`timescale 1ns/100ps
`default_nettype none
module dfz_prog_rx (
   input wire logic clk_i,
   input wire logic rst_i,
   dfz_if.rx bus
);
   import dfz_pkg::*;
   logic clk_d_r, clk_d_nxt, latch_d_r, latch_d_nxt, valid_r, valid_nxt;
   logic [15:0] shift_r, shift_nxt, word_r, word_nxt;

   always_comb begin
      clk_d_nxt = bus.prog_clk;
      latch_d_nxt = bus.prog_latch;
      shift_nxt = shift_r;
      word_nxt = word_r;
      valid_nxt = 1'b0;
      // Bits arrive MSB first on the rising program clock
      if (bus.prog_clk && !clk_d_r) begin
         shift_nxt = {shift_r[14:0], bus.prog_data};
      end
      // Words arriving while the block is held in reset are dropped whole
      if (bus.prog_latch && !latch_d_r && bus.rx_enable) begin
         word_nxt = shift_r;
         valid_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_d_r <= 1'b0;
         latch_d_r <= 1'b0;
         shift_r <= 16'h0000;
         word_r <= 16'h0000;
         valid_r <= 1'b0;
      end else begin
         clk_d_r <= clk_d_nxt;
         latch_d_r <= latch_d_nxt;
         shift_r <= shift_nxt;
         word_r <= word_nxt;
         valid_r <= valid_nxt;
      end
   end

   assign bus.word = word_r;
   assign bus.word_valid = valid_r;
endmodule
`default_nettype wire

// ===== hw/dfz_zero_det.sv
// Zero-run detector: counts bit clocks of all-zero input data
`timescale 1ns/100ps
`default_nettype none
module dfz_zero_det #(
   parameter int LIMIT = 65536
) (
   input wire logic clk_i,
   input wire logic rst_i,
   dfz_if.det bus
);
   import dfz_pkg::*;
   localparam int CW = $clog2(LIMIT + 1);
   localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic flag_r, flag_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      flag_nxt = flag_r;
      if (!bus.det_enable) begin
         cnt_nxt = '0;
         flag_nxt = 1'b0;
      end else if (bus.bclk_rise) begin
         if (bus.data_bit) begin
            cnt_nxt = '0;
            flag_nxt = 1'b0;
         end else if (cnt_r != LIMIT_C) begin
            cnt_nxt = cnt_r + CW'(1);
            flag_nxt = (cnt_r + CW'(1)) == LIMIT_C;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
         flag_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         flag_r <= flag_nxt;
      end
   end

   assign bus.zero_flag = flag_r;
endmodule
`default_nettype wire

// ===== hw/dfz_top.sv
// Format, rate and zero-detect mode control of a stereo audio converter
`timescale 1ns/100ps
`default_nettype none
`include "dfz_map.svh"

// Overview of operation
// - A program word lands in this mode register only when both select bits are 1.
// - Bit 0 picks right-justified framing (0) or I2S framing (1).
// - Bit 1 low: word select high means left; bit 1 high reverses it.
// - Bit 2 high: left attenuation value drives both channels.
// - Bit 2 low: each channel uses its own attenuation value.
// - Bit 3 picks system clock ratio 384 (0) or 256 (1) times sample rate.
// - Bits 5:4 pick normal, double or half rate; code 11 reserved.
// - Bits 7:6 pick the 44.1, 48 or 32 kHz family; code 11 reserved.
// - Bit 8 low disables zero detection; zero input never forces the outputs.
// - When enabled, count all-zero bit clocks and flag at 65536.
// - A flagged zero run forces both outputs to midscale at once.
// - While power-on reset is active, both outputs are held at midscale.
// - Host drives external reset low; outputs stay midscale while it is low.
// - After external reset rises, 1024 system clocks of init precede normal output.
// - Input to output delay is 11.125 sample periods.
// - Interpolate by eight; total oversampling 48x at ratio 384, 64x at 256.
// - Operation-disable bit forces midscale; zero detection acts only when it is 0.
// - Program words are ignored while the external reset pin is low.
module dfz_top #(
   parameter int INIT_CYCLES = `DFZ_INIT_CYCLES,
   parameter int ZERO_LIMIT = `DFZ_ZERO_LIMIT,
   parameter int SAMPLE_W = `DFZ_SAMPLE_W
) (
   // Clock and power-on reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // External reset pin
   input wire logic EXTERNAL_RESET_N_I,
   // Three-wire program port
   input wire logic PROG_CLK_I,
   input wire logic PROG_DATA_I,
   input wire logic PROG_LATCH_I,
   // Audio serial input
   input wire logic BIT_CLOCK_IN_I,
   input wire logic WORD_SELECT_IN_I,
   input wire logic AUDIO_DATA_I,
   // Decoded samples and adjacent control
   input wire logic SAMPLE_STROBE_I,
   input wire logic [SAMPLE_W-1:0] LEFT_SAMPLE_I,
   input wire logic [SAMPLE_W-1:0] RIGHT_SAMPLE_I,
   input wire logic OUTPUT_FORCE_MIDSCALE_I,
   input wire logic [7:0] ATTEN_LEFT_I,
   input wire logic [7:0] ATTEN_RIGHT_I,
   // Mode decode
   output logic [`DFZ_MODE_W-1:0] MODE_WORD_O,
   output logic INPUT_FRAMING_SELECT_O,
   output logic LEFT_CHANNEL_ACTIVE_O,
   output logic [7:0] ATTEN_LEFT_O,
   output logic [7:0] ATTEN_RIGHT_O,
   output logic [8:0] SYSCLK_RATIO_O,
   output logic [6:0] OVERSAMPLE_RATIO_O,
   output logic [3:0] INTERP_FACTOR_O,
   output dfz_pkg::dfz_multiple_type RATE_MULTIPLE_O,
   output dfz_pkg::dfz_group_type RATE_GROUP_O,
   output logic RATE_RESERVED_O,
   output logic [16:0] SAMPLE_RATE_HZ_O,
   output logic [6:0] LATENCY_EIGHTHS_O,
   output logic [12:0] LATENCY_SYSCLK_O,
   // Output stage
   output logic INIT_BUSY_O,
   output logic ZERO_FLAG_O,
   output logic MIDSCALE_LEVEL_O,
   output logic [SAMPLE_W-1:0] LEFT_OUT_O,
   output logic [SAMPLE_W-1:0] RIGHT_OUT_O
);
   import dfz_pkg::*;

   localparam int IW = $clog2(INIT_CYCLES + 1);
   localparam logic [IW-1:0] INIT_LAST = IW'(INIT_CYCLES - 1);
   localparam logic [SAMPLE_W-1:0] MID = SAMPLE_W'(`DFZ_MIDSCALE);

   // --------------------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------------------
   function automatic logic [16:0] rate_hz(input dfz_group_type g, input dfz_multiple_type m);
      logic [16:0] base;
      base = 17'h0_0000;
      case (g)
         DFZ_GRP_441: base = `DFZ_HZ_441;
         DFZ_GRP_48: base = `DFZ_HZ_48;
         DFZ_GRP_32: base = `DFZ_HZ_32;
         default: base = 17'h0_0000;
      endcase
      case (m)
         DFZ_MULT_NORMAL: rate_hz = base;
         DFZ_MULT_DOUBLE: rate_hz = {base[15:0], 1'b0};
         DFZ_MULT_HALF: rate_hz = {1'b0, base[16:1]};
         default: rate_hz = 17'h0_0000;
      endcase
   endfunction

   // Delay in system clocks is eighths of a sample period times ratio over eight
   function automatic logic [12:0] latency_clocks(input logic [8:0] ratio);
      logic [15:0] prod;
      prod = 16'(`DFZ_LATENCY_EIGHTHS) * 16'(ratio);
      latency_clocks = prod[15:3];
   endfunction

   // --------------------------------------------------------------------------
   // Sub-blocks
   // --------------------------------------------------------------------------
   dfz_if link ();

   dfz_prog_rx u_rx (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .bus(link.rx)
   );

   dfz_zero_det #(
      .LIMIT(ZERO_LIMIT)
   ) u_det (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .bus(link.det)
   );

   logic [`DFZ_MODE_W-1:0] mode_r, mode_nxt;
   logic bclk_d_r, bclk_d_nxt;

   assign link.prog_clk = PROG_CLK_I;
   assign link.prog_data = PROG_DATA_I;
   assign link.prog_latch = PROG_LATCH_I;
   assign link.rx_enable = EXTERNAL_RESET_N_I;
   assign link.bclk_rise = BIT_CLOCK_IN_I && !bclk_d_r;
   assign link.data_bit = AUDIO_DATA_I;
   // Counting clears while the reset pin is low so a stale run cannot mute a fresh start
   assign link.det_enable = mode_r[`DFZ_ZERO_EN_BIT] && EXTERNAL_RESET_N_I;

   // --------------------------------------------------------------------------
   // Mode register
   // --------------------------------------------------------------------------
   logic sel_match;
   assign sel_match = link.word[`DFZ_SEL_HI_BIT] && link.word[`DFZ_SEL_LO_BIT];

   always_comb begin
      mode_nxt = mode_r;
      bclk_d_nxt = BIT_CLOCK_IN_I;
      if (link.word_valid && sel_match && EXTERNAL_RESET_N_I) begin
         mode_nxt = link.word[`DFZ_MODE_W-1:0];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         mode_r <= `DFZ_MODE_RESET;
         bclk_d_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         bclk_d_r <= bclk_d_nxt;
      end
   end

   // --------------------------------------------------------------------------
   // Reset and initialisation sequencing
   // --------------------------------------------------------------------------
   dfz_state_type state_r, state_nxt;
   logic [IW-1:0] init_cnt_r, init_cnt_nxt;

   always_comb begin
      state_nxt = state_r;
      init_cnt_nxt = init_cnt_r;
      case (state_r)
         DFZ_ST_HOLD: begin
            init_cnt_nxt = '0;
            if (EXTERNAL_RESET_N_I) begin
               state_nxt = DFZ_ST_INIT;
            end
         end
         DFZ_ST_INIT: begin
            init_cnt_nxt = init_cnt_r + IW'(1);
            if (init_cnt_r == INIT_LAST) begin
               state_nxt = DFZ_ST_RUN;
            end
         end
         DFZ_ST_RUN: begin
            init_cnt_nxt = '0;
         end
         default: begin
            state_nxt = DFZ_ST_HOLD;
            init_cnt_nxt = '0;
         end
      endcase
      if (!EXTERNAL_RESET_N_I) begin
         state_nxt = DFZ_ST_HOLD;
         init_cnt_nxt = '0;
      end
   end

   // Power-on reset lands in the hold state, so it also runs the full init
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         state_r <= DFZ_ST_HOLD;
         init_cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         init_cnt_r <= init_cnt_nxt;
      end
   end

   // --------------------------------------------------------------------------
   // Decode and output stage
   // --------------------------------------------------------------------------
   logic force_mid;
   logic zero_mute;
   dfz_multiple_type mult_c;
   dfz_group_type group_c;
   logic [8:0] ratio_c;

   logic framing_r, framing_nxt, left_r, left_nxt, busy_r, busy_nxt;
   logic zero_r, zero_nxt, mid_r, mid_nxt, rsvd_r, rsvd_nxt;
   logic [7:0] att_l_r, att_l_nxt, att_r_r, att_r_nxt;
   logic [8:0] ratio_r, ratio_nxt;
   logic [6:0] osr_r, osr_nxt;
   dfz_multiple_type mult_r, mult_nxt;
   dfz_group_type group_r, group_nxt;
   logic [16:0] hz_r, hz_nxt;
   logic [12:0] lat_r, lat_nxt;
   logic [SAMPLE_W-1:0] out_l_r, out_l_nxt, out_r_r, out_r_nxt;

   // Zero muting only counts while the operation-disable bit is clear
   assign zero_mute = link.zero_flag && !OUTPUT_FORCE_MIDSCALE_I;
   assign force_mid = (state_r != DFZ_ST_RUN) || OUTPUT_FORCE_MIDSCALE_I || zero_mute;
   assign mult_c = dfz_multiple_type'(mode_r[`DFZ_MULT_HI_BIT:`DFZ_MULT_LO_BIT]);
   assign group_c = dfz_group_type'(mode_r[`DFZ_GROUP_HI_BIT:`DFZ_GROUP_LO_BIT]);
   assign ratio_c = mode_r[`DFZ_SYSCLK_BIT] ? `DFZ_RATIO_256 : `DFZ_RATIO_384;

   always_comb begin
      framing_nxt = mode_r[`DFZ_FRAMING_BIT];
      left_nxt = WORD_SELECT_IN_I ^ mode_r[`DFZ_WS_POL_BIT];
      att_l_nxt = ATTEN_LEFT_I;
      if (mode_r[`DFZ_SHARED_ATT_BIT]) begin
         att_r_nxt = ATTEN_LEFT_I;
      end else begin
         att_r_nxt = ATTEN_RIGHT_I;
      end
      ratio_nxt = ratio_c;
      osr_nxt = mode_r[`DFZ_SYSCLK_BIT] ? `DFZ_OSR_256 : `DFZ_OSR_384;
      mult_nxt = mult_c;
      group_nxt = group_c;
      // Reserved codes report a zero rate rather than a guessed one
      rsvd_nxt = (mult_c == DFZ_MULT_RSVD) || (group_c == DFZ_GRP_RSVD);
      hz_nxt = rate_hz(group_c, mult_c);
      lat_nxt = latency_clocks(ratio_c);
      busy_nxt = state_r != DFZ_ST_RUN;
      zero_nxt = link.zero_flag;
      mid_nxt = force_mid;
      out_l_nxt = out_l_r;
      out_r_nxt = out_r_r;
      if (force_mid) begin
         out_l_nxt = MID;
         out_r_nxt = MID;
      end else if (SAMPLE_STROBE_I) begin
         out_l_nxt = LEFT_SAMPLE_I;
         out_r_nxt = RIGHT_SAMPLE_I;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         framing_r <= 1'b0;
         left_r <= 1'b0;
         att_l_r <= 8'h00;
         att_r_r <= 8'h00;
         ratio_r <= `DFZ_RATIO_384;
         osr_r <= `DFZ_OSR_384;
         mult_r <= DFZ_MULT_NORMAL;
         group_r <= DFZ_GRP_441;
         rsvd_r <= 1'b0;
         hz_r <= `DFZ_HZ_441;
         lat_r <= 13'h0000;
         busy_r <= 1'b1;
         zero_r <= 1'b0;
         mid_r <= 1'b1;
         out_l_r <= MID;
         out_r_r <= MID;
      end else begin
         framing_r <= framing_nxt;
         left_r <= left_nxt;
         att_l_r <= att_l_nxt;
         att_r_r <= att_r_nxt;
         ratio_r <= ratio_nxt;
         osr_r <= osr_nxt;
         mult_r <= mult_nxt;
         group_r <= group_nxt;
         rsvd_r <= rsvd_nxt;
         hz_r <= hz_nxt;
         lat_r <= lat_nxt;
         busy_r <= busy_nxt;
         zero_r <= zero_nxt;
         mid_r <= mid_nxt;
         out_l_r <= out_l_nxt;
         out_r_r <= out_r_nxt;
      end
   end

   assign MODE_WORD_O = mode_r;
   assign INPUT_FRAMING_SELECT_O = framing_r;
   assign LEFT_CHANNEL_ACTIVE_O = left_r;
   assign ATTEN_LEFT_O = att_l_r;
   assign ATTEN_RIGHT_O = att_r_r;
   assign SYSCLK_RATIO_O = ratio_r;
   assign OVERSAMPLE_RATIO_O = osr_r;
   assign INTERP_FACTOR_O = `DFZ_INTERP;
   assign RATE_MULTIPLE_O = mult_r;
   assign RATE_GROUP_O = group_r;
   assign RATE_RESERVED_O = rsvd_r;
   assign SAMPLE_RATE_HZ_O = hz_r;
   assign LATENCY_EIGHTHS_O = `DFZ_LATENCY_EIGHTHS;
   assign LATENCY_SYSCLK_O = lat_r;
   assign INIT_BUSY_O = busy_r;
   assign ZERO_FLAG_O = zero_r;
   assign MIDSCALE_LEVEL_O = mid_r;
   assign LEFT_OUT_O = out_l_r;
   assign RIGHT_OUT_O = out_r_r;
endmodule
`default_nettype wire

// ===== bench/dfz_top_chk.sv
// Concurrent checks on the ports of the format/rate mode control top
`timescale 1ns/100ps
`default_nettype none
module dfz_top_chk #(
   parameter int INIT_CYCLES = 1024,
   parameter int SAMPLE_W = 24
) (
   // Inputs of the top
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic EXTERNAL_RESET_N_I,
   input wire logic PROG_LATCH_I,
   input wire logic WORD_SELECT_IN_I,
   input wire logic OUTPUT_FORCE_MIDSCALE_I,
   input wire logic [7:0] ATTEN_LEFT_I,
   input wire logic [7:0] ATTEN_RIGHT_I,
   // Outputs of the top
   input wire logic [8:0] MODE_WORD_O,
   input wire logic INPUT_FRAMING_SELECT_O,
   input wire logic LEFT_CHANNEL_ACTIVE_O,
   input wire logic [7:0] ATTEN_RIGHT_O,
   input wire logic [8:0] SYSCLK_RATIO_O,
   input wire logic [6:0] OVERSAMPLE_RATIO_O,
   input wire logic INIT_BUSY_O,
   input wire logic ZERO_FLAG_O,
   input wire logic MIDSCALE_LEVEL_O,
   input wire logic [SAMPLE_W-1:0] LEFT_OUT_O,
   input wire logic [SAMPLE_W-1:0] RIGHT_OUT_O
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   localparam int INIT_MAX = INIT_CYCLES + 4;
   wire logic quiet = LEFT_OUT_O == '0 && RIGHT_OUT_O == '0 && MIDSCALE_LEVEL_O;
   default clocking @(posedge CLK_I);
   endclocking
   default disable iff (RST_I);
   a_word_gate: assert property (
      !$past(RST_I) && MODE_WORD_O != $past(MODE_WORD_O) |-> $past(PROG_LATCH_I, 2)
      && !$past(PROG_LATCH_I, 3) && $past(EXTERNAL_RESET_N_I, 2)) else $error("stray mode");
   a_framing_sel: assert property (
      !$past(RST_I) |-> INPUT_FRAMING_SELECT_O == $past(MODE_WORD_O[0])) else $error("framing");
   a_ws_polarity: assert property (
      !$past(RST_I) && $stable(MODE_WORD_O) && $past(MODE_WORD_O) == $past(MODE_WORD_O, 2)
      |-> LEFT_CHANNEL_ACTIVE_O == ($past(WORD_SELECT_IN_I) ^ MODE_WORD_O[1]))
      else $error("polarity");
   a_shared_att: assert property (
      !$past(RST_I) && $stable(MODE_WORD_O) && $past(MODE_WORD_O) == $past(MODE_WORD_O, 2)
      |-> ATTEN_RIGHT_O == (MODE_WORD_O[2] ? $past(ATTEN_LEFT_I) : $past(ATTEN_RIGHT_I)))
      else $error("attenuation");
   a_ratio_osr: assert property (
      !$past(RST_I) |-> SYSCLK_RATIO_O == ($past(MODE_WORD_O[3]) ? 9'h100 : 9'h180)
      && OVERSAMPLE_RATIO_O == ($past(MODE_WORD_O[3]) ? 7'h40 : 7'h30)) else $error("ratio");
   a_zero_off: assert property (
      !MODE_WORD_O[8] && !$past(MODE_WORD_O[8]) && !$past(MODE_WORD_O[8], 2)
      |-> !ZERO_FLAG_O) else $error("zero flag while off");
   a_zero_mid: assert property (
      ZERO_FLAG_O |-> quiet) else $error("zero run not forced");
   a_busy_mid: assert property (
      INIT_BUSY_O && $past(INIT_BUSY_O) |-> quiet) else $error("busy not forced");
   a_pin_hold: assert property (
      !$past(EXTERNAL_RESET_N_I) && !$past(EXTERNAL_RESET_N_I, 2) |-> quiet && INIT_BUSY_O)
      else $error("pin reset not forced");
   a_init_len: assert property (
      $rose(EXTERNAL_RESET_N_I) |-> INIT_BUSY_O [*8] ##[1:INIT_MAX] !INIT_BUSY_O)
      else $error("init length");
   a_disable_mid: assert property (
      $past(OUTPUT_FORCE_MIDSCALE_I) && $past(OUTPUT_FORCE_MIDSCALE_I, 2) |-> quiet)
      else $error("disable not forced");
endmodule
bind dfz_top dfz_top_chk #(.INIT_CYCLES(INIT_CYCLES), .SAMPLE_W(SAMPLE_W)) chk_u (
   .CLK_I, .RST_I, .EXTERNAL_RESET_N_I, .PROG_LATCH_I, .WORD_SELECT_IN_I,
   .OUTPUT_FORCE_MIDSCALE_I, .ATTEN_LEFT_I, .ATTEN_RIGHT_I, .MODE_WORD_O,
   .INPUT_FRAMING_SELECT_O, .LEFT_CHANNEL_ACTIVE_O, .ATTEN_RIGHT_O, .SYSCLK_RATIO_O,
   .OVERSAMPLE_RATIO_O, .INIT_BUSY_O, .ZERO_FLAG_O, .MIDSCALE_LEVEL_O, .LEFT_OUT_O,
   .RIGHT_OUT_O);
`default_nettype wire

// ===== bench/dfz_host.sv
// Host controller model: three-wire program port and external reset pin
`timescale 1ns/100ps
`default_nettype none
module dfz_host (
   // Clock
   input wire logic clk_i,
   // Program port and reset pin
   output logic prog_clk_o,
   output logic prog_data_o,
   output logic prog_latch_o,
   output logic ext_rst_n_o
);
   // ----------------------------------------------------------------
   // Host tasks
   // ----------------------------------------------------------------
   initial begin
      prog_clk_o = 1'b0;
      prog_data_o = 1'b0;
      prog_latch_o = 1'b0;
      ext_rst_n_o = 1'b1;
   end
   // A slow host stretches each clock phase by extra cycles
   task automatic send(input logic [15:0] w, input int slow);
      for (int i = 15; i >= 0; i--) begin
         @(posedge clk_i);
         prog_data_o <= w[i];
         prog_clk_o <= 1'b0;
         repeat (slow + 1) @(posedge clk_i);
         prog_clk_o <= 1'b1;
         repeat (slow) @(posedge clk_i);
      end
      @(posedge clk_i);
      prog_latch_o <= 1'b1;
      // Data no longer held after the latch, so show the inverse
      prog_data_o <= ~prog_data_o;
      @(posedge clk_i);
      prog_latch_o <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic set_pin(input logic v);
      @(posedge clk_i);
      ext_rst_n_o <= v;
   endtask
endmodule
`default_nettype wire

// ===== bench/dfz_top_test.sv
// Self-checking bench for the format/rate mode control block
`timescale 1ns/100ps
`default_nettype none
module dfz_top_test;
   import dfz_pkg::*;
   localparam int INIT_N = 8;
   localparam int ZERO_N = 16;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic bclk = 1'b0, ws = 1'b0, adata = 1'b0, strobe = 1'b0, dis = 1'b0;
   logic [23:0] l_smp = 24'h00_0000, r_smp = 24'h00_0000, lout, rout;
   logic [7:0] att_l = 8'h00, att_r = 8'h00, att_lo, att_ro;
   logic ext_n, p_clk, p_dat, p_lat, frm, lact, rsv, busy, zflag, mid;
   logic [8:0] mode, ratio;
   logic [6:0] osr, lat8;
   logic [3:0] interp;
   logic [16:0] hz_o;
   logic [12:0] lat_clk;
   dfz_multiple_type mult;
   dfz_group_type grp;
   int n_fail = 0;
   int tests_run = 0;
   // ----------------------------------------------------------------
   // Harness and tasks
   // ----------------------------------------------------------------
   initial forever #2.5 clk = ~clk;
   dfz_host host_u (.clk_i(clk), .prog_clk_o(p_clk), .prog_data_o(p_dat),
      .prog_latch_o(p_lat), .ext_rst_n_o(ext_n));
   dfz_top #(.INIT_CYCLES(INIT_N), .ZERO_LIMIT(ZERO_N)) dut_u (.CLK_I(clk), .RST_I(rst),
      .EXTERNAL_RESET_N_I(ext_n), .PROG_CLK_I(p_clk), .PROG_DATA_I(p_dat),
      .PROG_LATCH_I(p_lat), .BIT_CLOCK_IN_I(bclk), .WORD_SELECT_IN_I(ws),
      .AUDIO_DATA_I(adata), .SAMPLE_STROBE_I(strobe), .LEFT_SAMPLE_I(l_smp),
      .RIGHT_SAMPLE_I(r_smp), .OUTPUT_FORCE_MIDSCALE_I(dis), .ATTEN_LEFT_I(att_l),
      .ATTEN_RIGHT_I(att_r), .MODE_WORD_O(mode), .INPUT_FRAMING_SELECT_O(frm),
      .LEFT_CHANNEL_ACTIVE_O(lact), .ATTEN_LEFT_O(att_lo), .ATTEN_RIGHT_O(att_ro),
      .SYSCLK_RATIO_O(ratio), .OVERSAMPLE_RATIO_O(osr), .INTERP_FACTOR_O(interp),
      .RATE_MULTIPLE_O(mult), .RATE_GROUP_O(grp), .RATE_RESERVED_O(rsv),
      .SAMPLE_RATE_HZ_O(hz_o), .LATENCY_EIGHTHS_O(lat8), .LATENCY_SYSCLK_O(lat_clk),
      .INIT_BUSY_O(busy), .ZERO_FLAG_O(zflag), .MIDSCALE_LEVEL_O(mid),
      .LEFT_OUT_O(lout), .RIGHT_OUT_O(rout));
   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_run;
      int i;
      i = 0;
      while (busy !== 1'b0 && i < 100) begin
         cyc(1);
         i++;
      end
      if (i == 100) begin
         n_fail++;
         $display("wrong value at %0t: init never ended", $time);
         end_sim();
      end
   endtask
   task automatic bclks(input int n, input logic d);
      repeat (n) begin
         @(posedge clk);
         bclk <= 1'b1;
         adata <= d;
         @(posedge clk);
         bclk <= 1'b0;
      end
      cyc(2);
   endtask
   task automatic smp(input logic [23:0] l, input logic [23:0] r);
      @(posedge clk);
      strobe <= 1'b1;
      l_smp <= l;
      r_smp <= r;
      @(posedge clk);
      strobe <= 1'b0;
      cyc(1);
   endtask
   function automatic logic [16:0] hz(input int g, input int m);
      logic [16:0] b;
      b = (g == 0) ? 17'h0_AC44 : (g == 1) ? 17'h0_BB80 : 17'h0_7D00;
      if (g == 3 || m == 3) return 17'h0_0000;
      return (m == 1) ? b << 1 : (m == 2) ? b >> 1 : b;
   endfunction
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      logic [15:0] w;
      int n;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      wait_run();
      chk(mode, 9'h000, "mode");
      chk(interp, 4'h8, "interp");
      chk(lat8, 7'h59, "eighths");
      $display("test reset done");
      for (int k = 0; k < 16; k++) begin
         w = {7'h03, 1'b0, 4'(k), 1'(k), 3'h0};
         host_u.send(w, k % 2);
         cyc(4);
         chk(mode, w[8:0], "mode");
         chk(mult, k % 4, "multiple");
         chk(grp, k / 4, "group");
         chk(rsv, k % 4 == 3 || k / 4 == 3, "reserved");
         chk(hz_o, hz(k / 4, k % 4), "rate");
         chk(ratio, (k % 2) ? 9'h100 : 9'h180, "ratio");
         chk(osr, (k % 2) ? 7'h40 : 7'h30, "osr");
         chk(lat_clk, (k % 2) ? 13'h0B20 : 13'h10B0, "latency");
      end
      $display("test decode done");
      host_u.send(16'h02FF, 0);
      cyc(4);
      chk(mode, 9'h0F8, "other register");
      host_u.set_pin(1'b0);
      host_u.send(16'h06C5, 0);
      chk(mode, 9'h0F8, "word in pin reset");
      chk({busy, mid, lout}, {2'b11, 24'h00_0000}, "pin reset");
      host_u.set_pin(1'b1);
      n = 0;
      while (busy === 1'b1 && n < 100) begin
         cyc(1);
         n++;
      end
      chk(n >= INIT_N && n <= INIT_N + 3, 1'b1, "init length");
      $display("test refusal done");
      @(posedge clk);
      att_l <= 8'h5A;
      att_r <= 8'hC3;
      ws <= 1'b1;
      host_u.send(16'h0607, 1);
      cyc(4);
      chk({frm, lact, att_lo, att_ro}, {2'b10, 16'h5A5A}, "swapped");
      host_u.send(16'h0600, 0);
      cyc(4);
      chk({frm, lact, att_lo, att_ro}, {2'b01, 16'h5AC3}, "plain");
      $display("test format done");
      smp(24'h12_3456, 24'hFE_DCBA);
      chk({lout, rout}, 48'h1234_56FE_DCBA, "sample");
      @(posedge clk);
      dis <= 1'b1;
      smp(24'h00_0777, 24'h00_0777);
      chk({mid, lout, rout}, {1'b1, 48'h0000_0000_0000}, "disabled");
      @(posedge clk);
      dis <= 1'b0;
      host_u.send(16'h0700, 0);
      smp(24'h00_0001, 24'h00_0002);
      bclks(ZERO_N - 1, 1'b0);
      chk({zflag, lout}, {1'b0, 24'h00_0001}, "before limit");
      bclks(1, 1'b0);
      chk({zflag, mid, lout, rout}, {2'b11, 48'h0000_0000_0000}, "limit");
      bclks(1, 1'b1);
      smp(24'h00_0055, 24'h00_0066);
      chk({zflag, lout, rout}, {1'b0, 48'h0000_5500_0066}, "release");
      host_u.send(16'h06FF, 0);
      bclks(ZERO_N + 4, 1'b0);
      chk({zflag, lout}, {1'b0, 24'h00_0055}, "detect off");
      $display("test zero run done");
      @(posedge clk);
      rst <= 1'b1;
      cyc(3);
      chk({mode, mid, lout}, {10'h001, 24'h00_0000}, "power-on reset");
      @(posedge clk);
      rst <= 1'b0;
      wait_run();
      $display("test second reset done");
      end_sim();
   end
endmodule
`default_nettype wire
